// *** ccr_pkg.sv ***
`default_nettype none

package ccr_pkg;

  // sequencer states
  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,  // reset pin held, core idle, pins released
    ST_SEQ   = 2'b01,  // internal reset sequence running
    ST_RUN   = 2'b10,  // core running at full speed
    ST_PROBE = 2'b11   // core halted, probe access open
  } rst_state_t;

  // strap field and codes
  localparam int           STRAP_W        = 3;
  localparam int           RATIO_W        = 4;
  localparam logic [2:0]   STRAP_RESERVED = 3'h7;
  localparam logic [3:0]   RATIO_DEFAULT  = 4'h4;

  // core clock rate and internal reset sequence length
  localparam int           CORE_CLK_MHZ   = 250;
  localparam int           SEQ_TIME_NS    = 256;
  localparam int           SEQ_CYCLES     = (SEQ_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int           SEQ_W          = 12;

  // values after reset and synchroniser depth
  localparam logic [3:0]   DIV_RST        = 4'h0;
  localparam logic [11:0]  SEQ_RST        = 12'h000;
  localparam int           SYNC_DEPTH     = 2;

  // status group driven out of the block
  typedef struct packed
  {
    logic               core_idle;    // core parked in idle
    logic               reset_done;   // internal reset complete
    logic               pins_oe;      // high while outputs may drive
    logic               dram_por;     // synchronised dram power-on reset
    logic               ratio_bad;    // reserved strap code seen
    logic [RATIO_W-1:0] ratio;        // multiple in use
  } status_t;

  // strap code to clock multiple; reserved code falls back to default
  function automatic logic [3:0] ratio_of(input logic [2:0] strap);
    logic [3:0] r;
    r = RATIO_DEFAULT;
    case (strap)
      3'h0:    r = 4'h4;
      3'h1:    r = 4'h5;
      3'h2:    r = 4'h6;
      3'h3:    r = 4'h7;
      3'h4:    r = 4'h8;
      3'h5:    r = 4'ha;
      3'h6:    r = 4'hc;
      default: r = RATIO_DEFAULT;
    endcase
    return r;
  endfunction

endpackage

`default_nettype wire

// *** ccr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// multi-stage level synchroniser for asynchronous pins
module ccr_sync #(
  parameter int   STAGES  = ccr_pkg::SYNC_DEPTH,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output var  logic o_sync
);

  // stage chain; stage 0 is read only by stage 1
  logic [STAGES-1:0] chain_r;

  // refuse a chain too short to settle metastability
  if (STAGES < 2)
  begin : g_chk
    $error("ccr_sync needs at least two stages");
  end

  // shift the pin level through the chain
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      chain_r <= {STAGES{RST_VAL}};
    end
    else
    begin
      chain_r <= {chain_r[STAGES-2:0], i_async};
    end
  end

  // last stage is the clean level
  assign o_sync = chain_r[STAGES-1];

endmodule // ccr_sync

`default_nettype wire

// *** core_clock_ratio_and_reset.sv ***
`timescale 1ns/1ps
`default_nettype none

module core_clock_ratio_and_reset #(
  parameter int SEQ_CYCLES = ccr_pkg::SEQ_CYCLES
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_reset_pin_n,
  input  wire logic                        i_dram_por_n,
  input  wire logic [ccr_pkg::STRAP_W-1:0] i_core_ratio_strap,
  input  wire logic                        i_core_halted,
  input  wire logic                        i_probe_req,
  input  wire logic                        i_probe_done,
  output var  logic                        o_sys_clk_en,
  output var  logic                        o_bus_clk_en,
  output var  logic                        o_probe_ack,
  output var  logic                        o_core_run,
  output var  ccr_pkg::status_t            o_status
);

  // whole state of the block
  typedef struct packed
  {
    ccr_pkg::rst_state_t          state;     // sequencer state
    logic [ccr_pkg::RATIO_W-1:0]  div_cnt;   // core cycles in system period
    logic                         bus_ph;    // half-rate bus phase
    logic [ccr_pkg::SEQ_W-1:0]    seq_cnt;   // reset sequence counter
    logic                         sclk_en;   // system clock enable pulse
    logic                         bus_en;    // bus clock enable pulse
    logic                         probe_ack; // probe access granted
    logic                         run;       // core running at full speed
    ccr_pkg::status_t             status;    // status group
  } ctl_t;

  ctl_t ctl_r;     // registered state
  ctl_t ctl_nxt;   // next state

  logic rst_pin_s;   // synchronised reset pin, active low
  logic por_s;       // synchronised dram por pin, active low
  logic rst_active;  // synchronised reset pin asserted

  // refuse sequence lengths the counter cannot hold
  if (SEQ_CYCLES < 1 || SEQ_CYCLES >= (1 << ccr_pkg::SEQ_W))
  begin : g_chk
    $error("SEQ_CYCLES out of range for the sequence counter");
  end

  localparam logic [ccr_pkg::SEQ_W-1:0] SEQ_LAST = ccr_pkg::SEQ_W'(SEQ_CYCLES - 1);

  ccr_sync #(
    .STAGES  (ccr_pkg::SYNC_DEPTH),
    .RST_VAL (1'b0)
  ) u_sync_rst (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_reset_pin_n),
    .o_sync    (rst_pin_s)
  );

  ccr_sync #(
    .STAGES  (ccr_pkg::SYNC_DEPTH),
    .RST_VAL (1'b0)
  ) u_sync_por (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_dram_por_n),
    .o_sync    (por_s)
  );

  // reset pin only; system reset acts in the state register
  assign rst_active = ~rst_pin_s;

  // next-state logic
  always_comb
  begin
    ctl_nxt                   = ctl_r;
    ctl_nxt.sclk_en           = 1'b0;
    ctl_nxt.status.dram_por   = ~por_s;

    ctl_nxt.bus_ph = ~ctl_r.bus_ph;
    ctl_nxt.bus_en = ~ctl_r.bus_ph;

    if (ctl_r.div_cnt == ctl_r.status.ratio - 4'h1)
    begin
      // pulse aligned to the same counter wrap
      ctl_nxt.div_cnt = ccr_pkg::DIV_RST;
      ctl_nxt.sclk_en = 1'b1;
    end
    else
    begin
      // still inside the system period
      ctl_nxt.div_cnt = ctl_r.div_cnt + 4'h1;
    end

    case (ctl_r.state)
      ccr_pkg::ST_RESET:
      begin
        ctl_nxt.status.ratio     = ccr_pkg::ratio_of(i_core_ratio_strap);
        ctl_nxt.status.ratio_bad = (i_core_ratio_strap == ccr_pkg::STRAP_RESERVED);
        ctl_nxt.div_cnt          = ccr_pkg::DIV_RST;
        ctl_nxt.seq_cnt          = ccr_pkg::SEQ_RST;
        if (!rst_active)
        begin
          // release: begin internal sequence
          ctl_nxt.state = ccr_pkg::ST_SEQ;
        end
      end
      ccr_pkg::ST_SEQ:
      begin
        if (ctl_r.seq_cnt == SEQ_LAST)
        begin
          ctl_nxt.state             = ccr_pkg::ST_RUN;
          ctl_nxt.status.reset_done = 1'b1;
          ctl_nxt.status.core_idle  = 1'b0;
          ctl_nxt.status.pins_oe    = 1'b1;
          ctl_nxt.run               = 1'b1;
        end
        else
        begin
          // keep counting
          ctl_nxt.seq_cnt = ctl_r.seq_cnt + 12'h001;
        end
      end
      ccr_pkg::ST_RUN:
      begin
        if (i_probe_req && i_core_halted)
        begin
          ctl_nxt.state     = ccr_pkg::ST_PROBE;
          ctl_nxt.probe_ack = 1'b1;
          ctl_nxt.run       = 1'b0;
        end
      end
      ccr_pkg::ST_PROBE:
      begin
        if (i_probe_done)
        begin
          ctl_nxt.state     = ccr_pkg::ST_RUN;
          ctl_nxt.probe_ack = 1'b0;
          ctl_nxt.run       = 1'b1;
        end
      end
      default:
      begin
        // unreachable encodings recover to reset
        ctl_nxt.state = ccr_pkg::ST_RESET;
      end
    endcase

    if (rst_active)
    begin
      ctl_nxt.state             = ccr_pkg::ST_RESET;
      ctl_nxt.status.core_idle  = 1'b1;
      ctl_nxt.status.reset_done = 1'b0;
      ctl_nxt.status.pins_oe    = 1'b0;
      ctl_nxt.probe_ack         = 1'b0;
      ctl_nxt.run               = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ctl_r                   <= '0;
      ctl_r.state             <= ccr_pkg::ST_RESET;
      ctl_r.status.ratio      <= ccr_pkg::RATIO_DEFAULT;
      ctl_r.status.core_idle  <= 1'b1;
      ctl_r.status.dram_por   <= 1'b1;
    end
    else
    begin
      ctl_r <= ctl_nxt;
    end
  end

  // outputs straight from the state register
  assign o_sys_clk_en = ctl_r.sclk_en;
  assign o_bus_clk_en = ctl_r.bus_en;
  assign o_probe_ack  = ctl_r.probe_ack;
  assign o_core_run   = ctl_r.run;
  assign o_status     = ctl_r.status;

endmodule // core_clock_ratio_and_reset

`default_nettype wire

// *** ccr_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_chk #(
  parameter int SEQ_CYCLES = 4
) (
  input wire logic                        i_clk_sys,
  input wire logic                        i_sys_rst,
  input wire logic                        i_reset_pin_n,
  input wire logic                        i_dram_por_n,
  input wire logic [ccr_pkg::STRAP_W-1:0] i_core_ratio_strap,
  input wire logic                        i_core_halted,
  input wire logic                        i_probe_req,
  input wire logic                        i_probe_done,
  input wire logic                        o_sys_clk_en,
  input wire logic                        o_bus_clk_en,
  input wire logic                        o_probe_ack,
  input wire logic                        o_core_run,
  input wire ccr_pkg::status_t            o_status
);
  // multiple per strap code, reserved falls back to 4
  localparam logic [3:0] RT [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
  logic [7:0] gap_r;  // cycles since last system pulse
  logic [7:0] hi_r;   // cycles reset pin seen high
  logic       ok_r;   // core ran through whole gap
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // helper counters
  always_ff @(posedge i_clk_sys)
  begin
    gap_r <= (i_sys_rst || o_sys_clk_en) ? 8'h01 : gap_r + {7'h00, gap_r != 8'hff};
    ok_r  <= !i_sys_rst && o_core_run && (o_sys_clk_en || ok_r);
    hi_r  <= (i_sys_rst || !i_reset_pin_n) ? 8'h00 : hi_r + {7'h00, hi_r != 8'hff};
  end
  sclk_period_a : assert property (
    o_sys_clk_en && ok_r && o_core_run |-> gap_r == {4'h0, RT[i_core_ratio_strap]})
    else $error("system pulse period wrong");
  ratio_map_a : assert property (
    o_core_run |-> o_status.ratio == RT[i_core_ratio_strap]
      && o_status.ratio_bad == (i_core_ratio_strap == 3'h7))
    else $error("ratio field wrong");
  pin_idle_a : assert property (
    !i_reset_pin_n [*3] |=> o_status.core_idle && !o_core_run && !o_probe_ack)
    else $error("core not idle in reset");
  pins_off_a : assert property (
    !i_reset_pin_n [*3] |=> !o_status.pins_oe && !o_status.reset_done)
    else $error("pins driven during reset");
  done_time_a : assert property (
    $rose(o_status.reset_done) |-> hi_r >= 8'(SEQ_CYCLES + 2) && hi_r <= 8'(SEQ_CYCLES + 4))
    else $error("reset done at wrong time");
  done_bound_a : assert property (
    hi_r == 8'(SEQ_CYCLES + 5) |-> o_status.reset_done)
    else $error("reset done late");
  dram_sync_a : assert property (
    $stable(i_dram_por_n) [*4] |=> o_status.dram_por == !$past(i_dram_por_n))
    else $error("dram reset not following pin");
  bus_half_a : assert property (
    o_core_run && $past(o_core_run) |-> o_bus_clk_en != $past(o_bus_clk_en))
    else $error("bus enable not alternating");
  probe_grant_a : assert property (
    o_core_run && i_probe_req && i_core_halted && i_reset_pin_n && $past(i_reset_pin_n, 2)
      |=> o_probe_ack && !o_core_run)
    else $error("probe not granted");
  probe_deny_a : assert property (
    o_core_run && !o_probe_ack && !i_core_halted |=> !o_probe_ack)
    else $error("probe granted while running");
  probe_end_a : assert property (
    o_probe_ack && i_probe_done && i_reset_pin_n && $past(i_reset_pin_n, 2)
      |=> !o_probe_ack && o_core_run)
    else $error("full speed not resumed");
  cover property ($rose(o_status.reset_done));
  cover property (o_probe_ack ##1 i_probe_done);
  cover property (o_core_run && i_core_ratio_strap == 3'h7);
endmodule // ccr_chk
bind core_clock_ratio_and_reset ccr_chk #(.SEQ_CYCLES(SEQ_CYCLES)) chk (.*);
`default_nettype wire

// *** ccr_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_board (
  input  wire logic       i_clk_sys,
  input  wire logic       i_pwr_req,    // start a power cycle
  input  wire logic [2:0] i_new_strap,  // strap for next power-up
  input  wire logic       i_done,       // reset-done from block
  output wire logic       o_reset_pin_n,
  output wire logic       o_dram_por_n,
  output var  logic [2:0] o_strap
);
  logic [3:0] low_r = 4'ha;  // cycles of reset still to hold
  initial o_strap = 3'h0;
  // hold reset low long enough, strap moves only unpowered
  always @(posedge i_clk_sys)
  begin
    if (i_pwr_req)
      low_r <= 4'ha;
    else if (low_r != 4'h0)
      low_r <= low_r - 4'h1;
    if (low_r == 4'h5)
      o_strap <= i_new_strap;
  end
  assign o_reset_pin_n = (low_r == 4'h0);
  // reset-done looped to dram power-on reset
  assign o_dram_por_n = i_done;
endmodule // ccr_board
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [3:0] RT [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
  logic clk = 1'b0, rst = 1'b1, pwr = 1'b0, halted = 1'b0, preq = 1'b0, pdone = 1'b0;
  logic [2:0] nstrap = 3'h0, strap;  // strap request and board strap
  logic pin_n, por_n, sclk_en, bus_en, ack, run;
  ccr_pkg::status_t st;              // block status group
  int fail_count = 0, checked = 0;
  always #2 clk = ~clk;
  ccr_board board (.i_clk_sys(clk), .i_pwr_req(pwr), .i_new_strap(nstrap),
    .i_done(st.reset_done), .o_reset_pin_n(pin_n), .o_dram_por_n(por_n), .o_strap(strap));
  core_clock_ratio_and_reset #(.SEQ_CYCLES(4)) dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_reset_pin_n(pin_n), .i_dram_por_n(por_n), .i_core_ratio_strap(strap),
    .i_core_halted(halted), .i_probe_req(preq), .i_probe_done(pdone), .o_sys_clk_en(sclk_en),
    .o_bus_clk_en(bus_en), .o_probe_ack(ack), .o_core_run(run), .o_status(st));
  // compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // power cycle with a strap code, then measure the system pulse period
  task automatic t_ratio(input logic [2:0] code);
    int n;
    logic b;  // bus enable level one cycle back
    @(posedge clk) pwr <= 1'b1;
    nstrap <= code;
    @(posedge clk) pwr <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("idle", {st.core_idle, run, ack}, 3'h4);
    chk("released", {st.pins_oe, st.reset_done}, 2'h0);
    for (n = 0; n < 60 && st.reset_done !== 1'b1; n++) @(posedge clk) #1;
    if (n == 60)
    begin
      fail_count++;
      wrap_up();
    end
    chk("done", {st.pins_oe, run, st.core_idle}, 3'h6);
    repeat (4) @(posedge clk);
    #1;
    chk("dram", st.dram_por, 1'b0);
    chk("bad", st.ratio_bad, code == 3'h7);
    chk("ratio", {4'h0, st.ratio}, {4'h0, RT[code]});
    for (n = 0; n < 20 && sclk_en !== 1'b1; n++) @(posedge clk) #1;
    if (n == 20)
    begin
      fail_count++;
      wrap_up();
    end
    n = 0;
    do begin @(posedge clk) #1; n++; end while (sclk_en !== 1'b1 && n < 20);
    chk("period", 8'(n), {4'h0, RT[code]});
    if (n == 20)
      wrap_up();
    b = bus_en;
    @(posedge clk) #1;
    chk("bus", {7'h00, bus_en}, {7'h00, !b});
  endtask
  // probe refused while running, granted when halted, full speed after
  task automatic t_probe;
    @(posedge clk) preq <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("deny", {ack, run}, 2'h1);
    @(posedge clk) halted <= 1'b1;
    @(posedge clk) #1;
    chk("grant", {ack, run}, 2'h2);
    @(posedge clk) pdone <= 1'b1;
    preq <= 1'b0;
    @(posedge clk) pdone <= 1'b0;
    halted <= 1'b0;
    #1;
    chk("resume", {ack, run}, 2'h1);
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int c = 0; c < 8; c++) t_ratio(3'(c));
    t_probe();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
